/* File: verif/cmpc_top_checker.sv */
module cmpc_chk (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    // register access
    input wire logic [7:0]           sfr_addr,
    input wire logic [7:0]           sfr_wdata,
    input wire logic                 sfr_wr,
    input wire logic                 sfr_rd,
    input wire logic [7:0]           sfr_rdata_q,
    input wire logic [7:0]           bit_addr,
    input wire logic                 bit_wval,
    input wire logic                 bit_wr,
    // comparator side and outputs
    input wire logic                 cmp_in,
    input wire logic                 cmp_power_q,
    input wire cmpc_pkg::cmpc_hyst_t pos_hyst_sel_q,
    input wire cmpc_pkg::cmpc_hyst_t neg_hyst_sel_q,
    input wire logic [4:0]           pos_hyst_mv_q,
    input wire logic [4:0]           neg_hyst_mv_q,
    input wire cmpc_pkg::cmpc_mode_t response_mode_sel_q,
    input wire logic                 latched_out_q,
    input wire logic                 raw_out,
    input wire logic                 cmp_irq_q,
    input wire logic                 reset_src_q
);
    import cmpc_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // millivolt table kept apart from the design's decode
    function automatic logic [4:0] mv_of(input logic [1:0] c);
        return c == 2'h3 ? 5'h14 : c == 2'h2 ? 5'h0a : c == 2'h1 ? 5'h05 : 5'h00;
    endfunction : mv_of

    ////////////////////////////////////////////////////////////////////////////
    en_write_a: assert property (sfr_wr && sfr_addr == 8'hf8 && !bit_wr
        |=> cmp_power_q == $past(sfr_wdata[7])) else $error("enable write lost");
    en_bitwr_a: assert property (bit_wr && bit_addr == 8'hff && !sfr_wr
        |=> cmp_power_q == $past(bit_wval)) else $error("enable bit write lost");
    off_low_a: assert property (!cmp_power_q ##1 !cmp_power_q
        |-> !latched_out_q && !reset_src_q && !raw_out) else $error("output high while off");
    raw_pass_a: assert property (cmp_power_q |-> raw_out == cmp_in)
        else $error("raw output wrong");
    // three flops from pin to latched output, reset path shares it
    latch_lat_a: assert property (cmp_power_q && $past(cmp_power_q)
        |-> latched_out_q == $past(cmp_in, 3) && reset_src_q == latched_out_q)
        else $error("latched output latency wrong");
    // switching on over a high input lifts the pin but is no comparator edge
    rise_irq_a: assert property (cmp_power_q && $past(cmp_power_q) && $past(cmp_power_q, 2)
        && $rose(latched_out_q) |=> cmp_irq_q) else $error("no request on rise");
    fall_irq_a: assert property (cmp_power_q && $past(cmp_power_q) && $fell(latched_out_q)
        |=> cmp_irq_q) else $error("no request on fall");
    irq_sticky_a: assert property (cmp_irq_q && !sfr_wr && !bit_wr |=> cmp_irq_q)
        else $error("flag cleared by hardware");
    // the result bit read back equals the latched pin in the same cycle
    result_rd_a: assert property (sfr_rd && sfr_addr == 8'hf8
        |=> sfr_rdata_q[7:6] == {$past(cmp_power_q), latched_out_q})
        else $error("result bit wrong");
    mode_rd_a: assert property (sfr_rd && sfr_addr == 8'h9d
        |=> sfr_rdata_q == {6'h00, $past(response_mode_sel_q)}) else $error("mode read wrong");
    unmapped_rd_a: assert property (sfr_rd && sfr_addr != 8'hf8 && sfr_addr != 8'h9d
        |=> sfr_rdata_q == 8'h00) else $error("unmapped read not zero");
    hyst_mv_a: assert property (pos_hyst_mv_q == mv_of(pos_hyst_sel_q)
        && neg_hyst_mv_q == mv_of(neg_hyst_sel_q)) else $error("hysteresis decode wrong");

    // main scenarios
    cover property ($rose(cmp_irq_q));
    cover property (cmp_power_q && $fell(latched_out_q));
    cover property (sfr_rd && sfr_addr == 8'h9d);
endmodule : cmpc_chk

bind cmpc_top cmpc_chk i_chk (.clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata_q, .bit_addr, .bit_wval, .bit_wr, .cmp_in, .cmp_power_q, .pos_hyst_sel_q,
    .neg_hyst_sel_q, .pos_hyst_mv_q, .neg_hyst_mv_q, .response_mode_sel_q,
    .latched_out_q, .raw_out, .cmp_irq_q, .reset_src_q);

/* File: verif/test_comparator_control_status.sv */
module test_comparator_control_status;
    timeunit 1ns;
    timeprecision 1ns;
    import cmpc_pkg::*;

    logic       clk = 1'h0, reset = 1'h1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata_q;
    logic       sfr_wr = 1'h0, sfr_rd = 1'h0, bit_wval = 1'h0, bit_wr = 1'h0;
    logic       cmp_in = 1'h0, cmp_power_q, latched_out_q, raw_out, cmp_irq_q, reset_src_q;
    logic [4:0] pos_hyst_mv_q, neg_hyst_mv_q;
    cmpc_hyst_t pos_hyst_sel_q, neg_hyst_sel_q;
    cmpc_mode_t response_mode_sel_q;
    int         failures = 0, check_count = 0, cycles = 0;
    logic [4:0] mv [4] = '{5'h00, 5'h05, 5'h0a, 5'h14};

    cmpc_top i_dut (.clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q,
        .bit_addr, .bit_wval, .bit_wr, .cmp_in, .cmp_power_q, .pos_hyst_sel_q,
        .neg_hyst_sel_q, .pos_hyst_mv_q, .neg_hyst_mv_q, .response_mode_sel_q,
        .latched_out_q, .raw_out, .cmp_irq_q, .reset_src_q);

    always #5 clk = ~clk;

    // whole run needs about 110 cycles; a hang is cut well above that
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // strobes held across one rising edge, dropped at the next falling one
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        @(negedge clk);
        sfr_wr = 1'h0;
    endtask : wr

    task bwr(input logic [7:0] a, input logic v);
        @(negedge clk);
        bit_addr = a;
        bit_wval = v;
        bit_wr = 1'h1;
        @(negedge clk);
        bit_wr = 1'h0;
    endtask : bwr

    task rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'h1;
        @(negedge clk);
        sfr_rd = 1'h0;
        chk(name, exp, sfr_rdata_q);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'h0;
        rd(8'hf8, 8'h00, "ctrl reset");
        rd(8'h9d, 8'h02, "mode reset");
        chk("power off", 8'h00, {7'h0, cmp_power_q});
        $display("test reset done");
        // every hysteresis and mode code; the two fields differ so a swap shows,
        // and bit 6 is written too but must not stick
        for (int i = 0; i < 4; i++) begin
            wr(8'hf8, {4'h4, i[1:0], ~i[1:0]});
            rd(8'hf8, {4'h0, i[1:0], ~i[1:0]}, "hyst fields");
            chk("pos sel", {6'h0, i[1:0]}, {6'h0, pos_hyst_sel_q});
            chk("neg sel", {6'h0, ~i[1:0]}, {6'h0, neg_hyst_sel_q});
            chk("pos mv", {3'h0, mv[i]}, {3'h0, pos_hyst_mv_q});
            chk("neg mv", {3'h0, mv[3-i]}, {3'h0, neg_hyst_mv_q});
            wr(8'h9d, {6'h3f, i[1:0]});
            rd(8'h9d, {6'h00, i[1:0]}, "mode");
            chk("mode out", {6'h0, i[1:0]}, {6'h0, response_mode_sel_q});
        end
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00, "unmapped");
        rd(8'hf8, 8'h0c, "unmapped write");
        $display("test fields done");
        wr(8'hf8, 8'h80);
        chk("power on", 8'h01, {7'h0, cmp_power_q});
        wr(8'hf8, 8'h80);
        cmp_in = 1'h1;
        #1 chk("raw rise", 8'h01, {7'h0, raw_out});
        repeat (6) @(negedge clk);
        chk("latched", 8'h01, {7'h0, latched_out_q});
        chk("reset src", 8'h01, {7'h0, reset_src_q});
        chk("irq rise", 8'h01, {7'h0, cmp_irq_q});
        rd(8'hf8, 8'he0, "rise flag");
        wr(8'hf8, 8'h80);
        rd(8'hf8, 8'hc0, "flags cleared");
        chk("irq clear", 8'h00, {7'h0, cmp_irq_q});
        cmp_in = 1'h0;
        repeat (6) @(negedge clk);
        chk("irq fall", 8'h01, {7'h0, cmp_irq_q});
        rd(8'hf8, 8'h90, "fall flag");
        repeat (20) @(negedge clk);
        rd(8'hf8, 8'h90, "fall sticky");
        bwr(8'hfc, 1'h0);
        rd(8'hf8, 8'h80, "bit clear");
        $display("test edges done");
        bwr(8'hff, 1'h0);
        cmp_in = 1'h1;
        #1 chk("raw off", 8'h00, {7'h0, raw_out});
        repeat (6) @(negedge clk);
        chk("latched off", 8'h00, {7'h0, latched_out_q});
        rd(8'hf8, 8'h00, "disabled");
        $display("test disable done");
        report_and_stop();
    end
endmodule : test_comparator_control_status

/* File: verilog/cmpc_edge.sv */
module cmpc_edge (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // edges are only reported while the comparator is on
    input  wire logic enable,
    // level in, pulses out
    cmpc_evt_if.edge_mp evt
);
    import cmpc_pkg::*;

    cmpc_edge_st_t st_q;
    cmpc_edge_st_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // previous level always tracks, so no stale edge appears on enable
    always_comb begin
        st_d      = st_q;
        st_d.prev = evt.level;
        st_d.rise = enable & evt.level & ~st_q.prev;
        st_d.fall = enable & ~evt.level & st_q.prev;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign evt.rise = st_q.rise;
    assign evt.fall = st_q.fall;

endmodule : cmpc_edge

/* File: verilog/cmpc_evt_if.sv */
// carries the synchronised comparator level and its edge pulses
interface cmpc_evt_if;
    logic level;
    logic rise;
    logic fall;

    modport sync_mp (output level);
    modport edge_mp (input level, output rise, output fall);
    modport ctrl_mp (input level, input rise, input fall);
endinterface : cmpc_evt_if

/* File: verilog/cmpc_pkg.sv */
package cmpc_pkg;

    // hysteresis field codes
    typedef enum logic [1:0] {
        CMPC_HYST_OFF  = 2'h0,
        CMPC_HYST_5MV  = 2'h1,
        CMPC_HYST_10MV = 2'h2,
        CMPC_HYST_20MV = 2'h3
    } cmpc_hyst_t;

    // response mode codes, fastest first
    typedef enum logic [1:0] {
        CMPC_MODE_0 = 2'h0,
        CMPC_MODE_1 = 2'h1,
        CMPC_MODE_2 = 2'h2,
        CMPC_MODE_3 = 2'h3
    } cmpc_mode_t;

    // synchroniser state
    typedef struct packed {
        logic meta;
        logic level;
    } cmpc_sync_st_t;

    // edge detector state
    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
    } cmpc_edge_st_t;

    // control block state
    typedef struct packed {
        logic       enable;
        logic       rise_flag;
        logic       fall_flag;
        cmpc_hyst_t pos_hyst_sel;
        cmpc_hyst_t neg_hyst_sel;
        cmpc_mode_t response_mode_sel;
        logic [7:0] rdata;
        logic       latched_out;
        logic       irq;
        logic       reset_src;
        logic       power;
        logic [4:0] pos_mv;
        logic [4:0] neg_mv;
    } cmpc_top_st_t;

endpackage : cmpc_pkg

/* File: verilog/cmpc_regs.svh */
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// register addresses on the special-function bus
`define CMPC_CTRL_ADDR   8'hf8
`define CMPC_MODE_ADDR   8'h9d
// bit address space: upper five bits select the control byte
`define CMPC_CTRL_BITSEL 5'h1f

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CMPC_CTRL_RESET  8'h00
`define CMPC_MODE_RESET  2'h2

////////////////////////////////////////////////////////////////////////////////
// control register field positions
`define CMPC_EN_BIT      7
`define CMPC_RES_BIT     6
`define CMPC_RISE_BIT    5
`define CMPC_FALL_BIT    4
`define CMPC_HYP_MSB     3
`define CMPC_HYP_LSB     2
`define CMPC_HYN_MSB     1
`define CMPC_HYN_LSB     0
// mode register field positions
`define CMPC_MODE_MSB    1
`define CMPC_MODE_LSB    0

////////////////////////////////////////////////////////////////////////////////
// hysteresis amounts in millivolts
`define CMPC_HYST_MV_OFF 5'h00
`define CMPC_HYST_MV_LO  5'h05
`define CMPC_HYST_MV_MID 5'h0a
`define CMPC_HYST_MV_HI  5'h14

`endif

/* File: verilog/cmpc_sync.sv */
module cmpc_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // raw comparator result, asynchronous to clk
    input  wire logic cmp_in,
    // synchronised level out
    cmpc_evt_if.sync_mp evt
);
    import cmpc_pkg::*;

    cmpc_sync_st_t st_q;
    cmpc_sync_st_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // two stages; meta feeds only the second stage
    always_comb begin
        st_d       = st_q;
        st_d.meta  = cmp_in;
        st_d.level = st_q.meta;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign evt.level = st_q.level;

endmodule : cmpc_sync

/* File: verilog/cmpc_top.sv */
`include "cmpc_regs.svh"

module cmpc_top (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // byte access on the special-function bus
    input  wire logic [7:0]             sfr_addr,
    input  wire logic [7:0]             sfr_wdata,
    input  wire logic                   sfr_wr,
    input  wire logic                   sfr_rd,
    output logic      [7:0]             sfr_rdata_q,
    // single-bit writes in the bit-addressable space
    input  wire logic [7:0]             bit_addr,
    input  wire logic                   bit_wval,
    input  wire logic                   bit_wr,
    // analog comparator side
    input  wire logic                   cmp_in,
    output logic                        cmp_power_q,
    output cmpc_pkg::cmpc_hyst_t        pos_hyst_sel_q,
    output cmpc_pkg::cmpc_hyst_t        neg_hyst_sel_q,
    output logic      [4:0]             pos_hyst_mv_q,
    output logic      [4:0]             neg_hyst_mv_q,
    output cmpc_pkg::cmpc_mode_t        response_mode_sel_q,
    // outputs toward pins, interrupt and reset logic
    output logic                        latched_out_q,
    output logic                        raw_out,
    output logic                        cmp_irq_q,
    output logic                        reset_src_q
);
    import cmpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // hysteresis code to millivolts, shared by both polarities
    function automatic logic [4:0] hyst_mv(input cmpc_hyst_t sel);
        logic [4:0] mv;
        mv = `CMPC_HYST_MV_OFF;
        unique case (sel)
            CMPC_HYST_OFF:  mv = `CMPC_HYST_MV_OFF;
            CMPC_HYST_5MV:  mv = `CMPC_HYST_MV_LO;
            CMPC_HYST_10MV: mv = `CMPC_HYST_MV_MID;
            CMPC_HYST_20MV: mv = `CMPC_HYST_MV_HI;
        endcase
        return mv;
    endfunction : hyst_mv

    // builds the control byte as software sees it
    function automatic logic [7:0] ctrl_image(input cmpc_top_st_t s, input logic res);
        logic [7:0] v;
        v = `CMPC_CTRL_RESET;
        v[`CMPC_EN_BIT]                   = s.enable;
        v[`CMPC_RES_BIT]                  = res;
        v[`CMPC_RISE_BIT]                 = s.rise_flag;
        v[`CMPC_FALL_BIT]                 = s.fall_flag;
        v[`CMPC_HYP_MSB:`CMPC_HYP_LSB]    = s.pos_hyst_sel;
        v[`CMPC_HYN_MSB:`CMPC_HYN_LSB]    = s.neg_hyst_sel;
        return v;
    endfunction : ctrl_image

    ////////////////////////////////////////////////////////////////////////////
    // synchroniser and edge detector

    cmpc_evt_if evt ();

    cmpc_sync u_sync (
        .clk    (clk),
        .reset  (reset),
        .cmp_in (cmp_in),
        .evt    (evt.sync_mp)
    );

    cmpc_top_st_t st_q;
    cmpc_top_st_t st_d;

    cmpc_edge u_edge (
        .clk    (clk),
        .reset  (reset),
        .enable (st_q.enable),
        .evt    (evt.edge_mp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    logic       ctrl_hit;
    logic       mode_hit;
    logic       bit_hit;
    logic [7:0] ctrl_new;
    logic       result;

    // decode; only the control byte is bit addressable
    assign ctrl_hit = sfr_wr & (sfr_addr == `CMPC_CTRL_ADDR);
    assign mode_hit = sfr_wr & (sfr_addr == `CMPC_MODE_ADDR);
    assign bit_hit  = bit_wr & (bit_addr[7:3] == `CMPC_CTRL_BITSEL);

    // result reads low while off, so stale data never shows
    assign result = st_q.enable & evt.level;

    // merge a byte write and a bit write into one new control image
    always_comb begin
        ctrl_new = ctrl_image(st_q, result);
        if (ctrl_hit) begin
            ctrl_new = sfr_wdata;
        end
        if (bit_hit) begin
            ctrl_new[bit_addr[2:0]] = bit_wval;
        end
    end

    always_comb begin
        st_d = st_q;

        // software-owned fields; the result bit is read only
        st_d.enable       = ctrl_new[`CMPC_EN_BIT];
        st_d.pos_hyst_sel = cmpc_hyst_t'(ctrl_new[`CMPC_HYP_MSB:`CMPC_HYP_LSB]);
        st_d.neg_hyst_sel = cmpc_hyst_t'(ctrl_new[`CMPC_HYN_MSB:`CMPC_HYN_LSB]);

        // sticky flags: an edge in the clearing cycle still sets the flag
        st_d.rise_flag = ctrl_new[`CMPC_RISE_BIT] | evt.rise;
        st_d.fall_flag = ctrl_new[`CMPC_FALL_BIT] | evt.fall;

        // response mode; upper bits of the byte are dropped
        if (mode_hit) begin
            st_d.response_mode_sel =
                cmpc_mode_t'(sfr_wdata[`CMPC_MODE_MSB:`CMPC_MODE_LSB]);
        end

        // hysteresis amounts follow the new selections
        st_d.pos_mv = hyst_mv(st_d.pos_hyst_sel);
        st_d.neg_mv = hyst_mv(st_d.neg_hyst_sel);

        // analog power follows the enable bit
        st_d.power = st_d.enable;

        // clocked outputs; forced low while off
        st_d.latched_out = st_q.enable & evt.level;
        st_d.reset_src   = st_q.enable & evt.level;

        // one request line for both edge kinds; cpu masks it
        st_d.irq = st_d.rise_flag | st_d.fall_flag;

        // read data one cycle after the strobe; unmapped reads zero
        if (sfr_rd) begin
            unique case (sfr_addr)
                `CMPC_CTRL_ADDR: st_d.rdata = ctrl_image(st_q, result);
                `CMPC_MODE_ADDR: st_d.rdata = {6'h00, st_q.response_mode_sel};
                default:         st_d.rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // everything resets to zero except the response mode
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q                   <= '0;
            st_q.response_mode_sel <= cmpc_mode_t'(`CMPC_MODE_RESET);
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign sfr_rdata_q         = st_q.rdata;
    assign cmp_power_q         = st_q.power;
    assign pos_hyst_sel_q      = st_q.pos_hyst_sel;
    assign neg_hyst_sel_q      = st_q.neg_hyst_sel;
    assign pos_hyst_mv_q       = st_q.pos_mv;
    assign neg_hyst_mv_q       = st_q.neg_mv;
    assign response_mode_sel_q = st_q.response_mode_sel;
    assign latched_out_q       = st_q.latched_out;
    assign cmp_irq_q           = st_q.irq;
    assign reset_src_q         = st_q.reset_src;

    // raw path has no clocked stage so it keeps working with clk stopped;
    // gated only by the enable flop, which holds its value in stop mode
    assign raw_out = cmp_in & st_q.enable;

endmodule : cmpc_top
